// ===== verilog/fm_pilot_clock_and_ignition_blanker.sv
// Pilot-locked sample clock generator and ignition interference absorber.
// Assumes the stereo decoder loop, host control bits and sample strobes share clk.
`timescale 1ns/100ps

`include "fm_blanker_consts.svh"

module fm_pilot_clock_and_ignition_blanker #(
    parameter int FRAC_W = `FRAC_BITS,
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic radio_mode,
    input wire logic preset_mode,
    input wire logic [DIV_W-1:0] div_int,
    input wire logic [FRAC_W-1:0] div_frac,
    input wire logic [15:0] trim_step,
    input wire logic [15:0] trim_limit,
    input wire logic loop_up,
    input wire logic loop_down,
    output logic sample_clk_en,
    output logic stereo_dec_en,
    output logic rds_converter_en,
    output logic mpx_converter_en,
    output logic level_filter_en,
    output logic signed [15:0] trim_value,
    input wire logic detector_a_enable,
    input wire logic detector_b_enable,
    input wire fm_blanker_pkg::coef_write_t coef_write,
    input wire fm_blanker_pkg::mpx_sample_t mpx_in,
    input wire fm_blanker_pkg::level_sample_t level_in,
    output fm_blanker_pkg::mpx_sample_t mpx_out,
    output logic mute_active,
    output logic dynamic_disable
);
    import fm_blanker_pkg::*;

    // ==================================================================
    // Pilot-locked sample clock
    // ==================================================================
    logic [DIV_W-1:0] cnt_q;
    logic [FRAC_W-1:0] acc_q;
    logic signed [16:0] trim_q;
    logic signed [16:0] trim_d;
    logic signed [FRAC_W+1:0] frac_sum;
    logic [FRAC_W-1:0] eff_frac;
    logic [FRAC_W:0] acc_sum;
    logic [DIV_W-1:0] base_div;
    logic tick;
    logic tick_q;

    // A zero integer part would stall the divider, so it is treated as one.
    assign base_div = (div_int == '0) ? DIV_W'(1) : div_int;
    assign tick = (cnt_q == DIV_W'(1));

    // The fraction plus trim saturates so a large trim never wraps the period.
    assign frac_sum = $signed({2'b00, div_frac}) + (FRAC_W+2)'(trim_q);
    always_comb begin
        if (frac_sum < 0) begin
            eff_frac = '0;
        end else if (frac_sum > $signed({2'b00, {FRAC_W{1'b1}}})) begin
            eff_frac = '1;
        end else begin
            eff_frac = frac_sum[FRAC_W-1:0];
        end
    end
    assign acc_sum = {1'b0, acc_q} + {1'b0, eff_frac};

    // Periods alternate between N and N+1 cycles; the carry picks the long one.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= DIV_W'(`DIV_INT_RST);
            acc_q <= '0;
        end else if (tick) begin
            acc_q <= acc_sum[FRAC_W-1:0];
            cnt_q <= base_div + DIV_W'(acc_sum[FRAC_W]);
        end else begin
            cnt_q <= cnt_q - DIV_W'(1);
        end
    end

    // Up asks for a faster rate, which shortens the period.
    always_comb begin
        trim_d = trim_q;
        if (loop_up && !loop_down) begin
            trim_d = trim_q - $signed({1'b0, trim_step});
        end else if (loop_down && !loop_up) begin
            trim_d = trim_q + $signed({1'b0, trim_step});
        end
        if (trim_d > $signed({1'b0, trim_limit})) begin
            trim_d = $signed({1'b0, trim_limit});
        end else if (trim_d < -$signed({1'b0, trim_limit})) begin
            trim_d = -$signed({1'b0, trim_limit});
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_q <= '0;
        end else if (preset_mode) begin
            trim_q <= '0;
        end else begin
            trim_q <= trim_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
        end
    end

    assign sample_clk_en = tick_q;
    // One shared enable keeps every radio path on the same pilot grid.
    assign stereo_dec_en = tick_q && radio_mode;
    assign rds_converter_en = tick_q && radio_mode;
    assign mpx_converter_en = tick_q;
    assign level_filter_en = tick_q && radio_mode;
    assign trim_value = trim_q[15:0];

    // ==================================================================
    // Absorber coefficients
    // ==================================================================
    logic [15:0] thr_a_q;
    logic [15:0] hold_a_q;
    logic [15:0] thr_b_q;
    logic [15:0] hold_b_q;
    logic [15:0] dev_limit_q;
    logic [15:0] dev_hold_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            thr_a_q <= `THR_A_RST;
            hold_a_q <= `HOLD_A_RST;
            thr_b_q <= `THR_B_RST;
            hold_b_q <= `HOLD_B_RST;
            dev_limit_q <= `DEV_LIMIT_RST;
            dev_hold_q <= `DEV_HOLD_RST;
        end else if (coef_write.wr) begin
            unique case (coef_write.sel)
                COEF_THR_A: begin
                    thr_a_q <= coef_write.data;
                end
                COEF_HOLD_A: begin
                    hold_a_q <= coef_write.data;
                end
                COEF_THR_B: begin
                    thr_b_q <= coef_write.data;
                end
                COEF_HOLD_B: begin
                    hold_b_q <= coef_write.data;
                end
                COEF_DEV_LIMIT: begin
                    dev_limit_q <= coef_write.data;
                end
                COEF_DEV_HOLD: begin
                    dev_hold_q <= coef_write.data;
                end
                default: begin
                end
            endcase
        end
    end

    // ==================================================================
    // Detectors
    // ==================================================================
    localparam int N_DET = 2;
    logic [N_DET-1:0] det_enable;
    logic [N_DET-1:0] det_valid;
    logic signed [`MPX_BITS-1:0] det_sample [N_DET];
    logic [15:0] det_threshold [N_DET];
    logic [15:0] det_hold [N_DET];
    logic [N_DET-1:0] det_mute;
    logic signed [`MPX_BITS-1:0] level_word;

    // The top bit is dropped so a glitched converter can never look negative.
    assign level_word = `MPX_BITS'({1'b0, level_in.data[`LEVEL_BITS-2:0]});

    // Slot 0 watches the multiplex samples, slot 1 the field-strength words.
    assign det_enable = {detector_b_enable, detector_a_enable};
    assign det_valid = {level_in.valid, mpx_in.valid};
    assign det_sample[0] = mpx_in.data;
    assign det_sample[1] = level_word;
    assign det_threshold[0] = thr_a_q;
    assign det_threshold[1] = thr_b_q;
    assign det_hold[0] = hold_a_q;
    assign det_hold[1] = hold_b_q;

    // Each slot keeps its own history and hold, so neither waits on the other.
    for (genvar i = 0; i < N_DET; i++) begin : g_det
        ignition_detector #(
            .W(`MPX_BITS)
        ) detector (
            .clk(clk),
            .sys_rst(sys_rst),
            .enable(det_enable[i]),
            .sample_valid(det_valid[i]),
            .sample(det_sample[i]),
            .threshold(det_threshold[i]),
            .hold(det_hold[i]),
            .mute(det_mute[i])
        );
    end

    // ==================================================================
    // Dynamic disable
    // ==================================================================
    logic [15:0] dev_cnt_q;
    logic [`MPX_BITS-1:0] mpx_mag;
    logic dev_hit;

    assign mpx_mag = mpx_in.data[`MPX_BITS-1] ? `MPX_BITS'(-mpx_in.data) : mpx_in.data;
    assign dev_hit = mpx_in.valid && (mpx_mag > dev_limit_q);

    // Held for a while after the peak, since deviation swings through zero often.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_cnt_q <= '0;
        end else if (dev_hit) begin
            dev_cnt_q <= (dev_hold_q == 16'h0000) ? 16'h0001 : dev_hold_q;
        end else if (mpx_in.valid && dev_cnt_q != 16'h0000) begin
            dev_cnt_q <= dev_cnt_q - 16'h0001;
        end
    end

    assign dynamic_disable = dev_hit || (dev_cnt_q != 16'h0000);

    // ==================================================================
    // Mute switch
    // ==================================================================
    logic mute_now;

    assign mute_now = (|det_mute) && !dynamic_disable;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mpx_out <= '0;
            mute_active <= 1'b0;
        end else begin
            mpx_out.valid <= mpx_in.valid;
            mute_active <= mute_now;
            if (mpx_in.valid) begin
                mpx_out.data <= mute_now ? '0 : mpx_in.data;
            end
        end
    end

endmodule

// ===== verilog/fm_blanker_consts.svh
// Holds the reset values and field widths of the pilot clock and blanker logic.
// Included by the package user files; holds definitions only.
`ifndef FM_BLANKER_CONSTS_SVH
`define FM_BLANKER_CONSTS_SVH

// ==================================================================
// Sample clock divider
// ==================================================================
`define SYNTH_CLK_HZ 10000000
`define SAMPLE_CLK_HZ 9728000
`define PILOT_MULT 512
`define FRAC_BITS 16
`define DIV_INT_RST 8'h01
`define DIV_FRAC_RST 16'h0728
`define TRIM_STEP_RST 16'h0001
`define TRIM_LIMIT_RST 16'h0010

// ==================================================================
// Interference absorber coefficients
// ==================================================================
`define MPX_BITS 16
`define LEVEL_BITS 9
`define THR_A_RST 16'h2000
`define HOLD_A_RST 16'h0010
`define THR_B_RST 16'h0020
`define HOLD_B_RST 16'h0010
`define DEV_LIMIT_RST 16'h6000
`define DEV_HOLD_RST 16'h0040

`endif

// ===== verilog/fm_blanker_pkg.sv
// Types shared by the pilot clock and blanker files.
// Assumes the constants header is on the include path.
`include "fm_blanker_consts.svh"

package fm_blanker_pkg;

    typedef struct packed {
        logic valid;
        logic signed [`MPX_BITS-1:0] data;
    } mpx_sample_t;

    typedef struct packed {
        logic valid;
        logic [`LEVEL_BITS-1:0] data;
    } level_sample_t;

    typedef enum logic [2:0] {
        COEF_THR_A = 3'h0,
        COEF_HOLD_A = 3'h1,
        COEF_THR_B = 3'h2,
        COEF_HOLD_B = 3'h3,
        COEF_DEV_LIMIT = 3'h4,
        COEF_DEV_HOLD = 3'h5
    } coef_sel_t;

    typedef struct packed {
        logic wr;
        coef_sel_t sel;
        logic [15:0] data;
    } coef_write_t;

endpackage

// ===== verilog/ignition_detector.sv
// One ignition-pulse detector: first difference, magnitude, threshold, mute hold.
// Assumes samples arrive as single-cycle valid strobes on clk.
`timescale 1ns/100ps

module ignition_detector #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] sample,
    input wire logic [15:0] threshold,
    input wire logic [15:0] hold,
    output logic mute
);

    logic signed [W-1:0] prev_q;
    logic signed [W:0] diff;
    logic [W:0] mag;
    logic [15:0] hold_q;
    logic hit;

    // High-frequency content is taken as the step between successive samples.
    assign diff = W'(1) == 0 ? '0 : ($signed({sample[W-1], sample}) - $signed({prev_q[W-1], prev_q}));
    assign mag = diff[W] ? (W+1)'(-diff) : diff;
    assign hit = enable && sample_valid && (mag > (W+1)'(threshold));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q <= '0;
        end else if (sample_valid) begin
            prev_q <= sample;
        end
    end

    // The hold counts samples so the mute spans the whole ignition burst.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= '0;
        end else if (!enable) begin
            hold_q <= '0;
        end else if (hit) begin
            hold_q <= (hold == 16'h0000) ? 16'h0001 : hold;
        end else if (sample_valid && hold_q != 16'h0000) begin
            hold_q <= hold_q - 16'h0001;
        end
    end

    assign mute = hit || (hold_q != 16'h0000);

endmodule

// ===== bench/blanker_properties.sv
// Checker for the pilot clock and blanker top ports.
// Bound from the bench top file; sees ports only.
`timescale 1ns/100ps

// ==========================================
// Properties
module blanker_properties #(
    parameter int FRAC_W = 16,
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic radio_mode,
    input wire logic preset_mode,
    input wire logic [DIV_W-1:0] div_int,
    input wire logic [15:0] trim_limit,
    input wire logic loop_up,
    input wire logic loop_down,
    input wire logic sample_clk_en,
    input wire logic stereo_dec_en,
    input wire logic rds_converter_en,
    input wire logic mpx_converter_en,
    input wire logic level_filter_en,
    input wire logic signed [15:0] trim_value,
    input wire fm_blanker_pkg::mpx_sample_t mpx_in,
    input wire fm_blanker_pkg::mpx_sample_t mpx_out,
    input wire logic mute_active,
    input wire logic dynamic_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_gate_enables: assert property (stereo_dec_en == (sample_clk_en && radio_mode)
        && level_filter_en == stereo_dec_en && mpx_converter_en == sample_clk_en)
        else $error("converter enables not tied to the sample tick");
    a_rds_follows: assert property (rds_converter_en == stereo_dec_en)
        else $error("rds enable differs from decoder enable");
    a_tick_gap: assert property (sample_clk_en && div_int > 1 && $stable(div_int)
        |=> !sample_clk_en) else $error("ticks closer than the divider");
    a_tick_recur: assert property (sample_clk_en |=> ##[0:255] sample_clk_en)
        else $error("sample tick stopped");
    a_preset_zero: assert property (preset_mode |=> trim_value == 0)
        else $error("trim not cleared in preset");
    a_trim_up: assert property (loop_up && !loop_down && !preset_mode
        |=> trim_value <= $past(trim_value)) else $error("up pulse raised trim");
    a_trim_clamp: assert property ($stable(trim_limit) |-> int'(trim_value) <= int'(trim_limit)
        && int'(trim_value) >= -int'(trim_limit)) else $error("trim beyond limit");
    a_out_lag: assert property (mpx_out.valid == $past(mpx_in.valid))
        else $error("output strobe not one cycle after input");
    a_mute_zero: assert property (mpx_out.valid && mute_active |-> mpx_out.data == 0)
        else $error("muted sample not zero");
    a_pass_clean: assert property (mpx_out.valid && !mute_active
        |-> mpx_out.data == $past(mpx_in.data)) else $error("sample altered");
    a_disable_pass: assert property (dynamic_disable && mpx_in.valid |=> !mute_active)
        else $error("muted while absorber disabled");

    c_mute: cover property (mpx_out.valid && mute_active);
    c_disable: cover property (dynamic_disable);
    c_trim: cover property (trim_value != 0);
endmodule

// ===== bench/decoder_loop_model.sv
// Stereo decoder loop stand-in: turns trim requests into loop pulses.
// The real loop runs at the sample rate, so pulses land only in the cycle after a tick.
`timescale 1ns/100ps

// ==========================================
// Loop model
module decoder_loop_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_clk_en,
    input wire logic req_up,
    input wire logic req_down,
    output logic loop_up,
    output logic loop_down
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_up <= 1'b0;
            loop_down <= 1'b0;
        end else begin
            loop_up <= req_up && sample_clk_en;
            loop_down <= req_down && sample_clk_en;
        end
    end
endmodule

// ===== bench/fm_pilot_clock_and_ignition_blanker_bench.sv
// Self-checking bench for the pilot clock and ignition blanker.
// Drives inputs at rising edges, checks outputs at falling edges.
`timescale 1ns/100ps

// ==========================================
// Bench top
module fm_pilot_clock_and_ignition_blanker_bench;
    import fm_blanker_pkg::*;
    localparam int DIVS [4] = '{1, 4, 2, 1};
    localparam int FRACS [4] = '{0, 0, 'h8000, 0};
    localparam int TICKS [4] = '{40, 10, 16, 40};
    logic clk, sys_rst, radio_mode, preset_mode, loop_up, loop_down, req_up, req_down;
    logic [7:0] div_int;
    logic [15:0] div_frac, trim_step, trim_limit;
    logic sample_clk_en, stereo_dec_en, rds_converter_en, mpx_converter_en, level_filter_en;
    logic signed [15:0] trim_value;
    logic detector_a_enable, detector_b_enable, mute_active, dynamic_disable;
    coef_write_t coef_write;
    mpx_sample_t mpx_in, mpx_out;
    level_sample_t level_in;
    int n_fail, total_checks, n_tick, n_dec;

    fm_pilot_clock_and_ignition_blanker dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .radio_mode(radio_mode),
        .preset_mode(preset_mode),
        .div_int(div_int),
        .div_frac(div_frac),
        .trim_step(trim_step),
        .trim_limit(trim_limit),
        .loop_up(loop_up),
        .loop_down(loop_down),
        .sample_clk_en(sample_clk_en),
        .stereo_dec_en(stereo_dec_en),
        .rds_converter_en(rds_converter_en),
        .mpx_converter_en(mpx_converter_en),
        .level_filter_en(level_filter_en),
        .trim_value(trim_value),
        .detector_a_enable(detector_a_enable),
        .detector_b_enable(detector_b_enable),
        .coef_write(coef_write),
        .mpx_in(mpx_in),
        .level_in(level_in),
        .mpx_out(mpx_out),
        .mute_active(mute_active),
        .dynamic_disable(dynamic_disable)
    );
    decoder_loop_model loop (.clk(clk), .sys_rst(sys_rst), .sample_clk_en(sample_clk_en),
        .req_up(req_up), .req_down(req_down), .loop_up(loop_up), .loop_down(loop_down));

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr_coef(input coef_sel_t sel, input logic [15:0] d);
        @(posedge clk) coef_write <= {1'b1, sel, d};
        @(posedge clk) coef_write.wr <= 1'b0;
    endtask

    task automatic send_level(input logic [8:0] v);
        @(posedge clk) level_in <= {1'b1, v};
        @(posedge clk) level_in.valid <= 1'b0;
    endtask

    task automatic send_mpx(input logic [15:0] v, input logic [15:0] exp, input logic m);
        @(posedge clk) mpx_in <= {1'b1, v};
        @(posedge clk) mpx_in.valid <= 1'b0;
        @(negedge clk);
        check(mpx_out.valid, 1);
        check(mpx_out.data, exp);
        check(mute_active, m);
    endtask

    task automatic count_ticks();
        n_tick = 0;
        n_dec = 0;
        repeat (40) @(negedge clk) begin
            n_tick += sample_clk_en + mpx_converter_en;
            n_dec += stereo_dec_en + rds_converter_en + level_filter_en;
        end
    endtask

    // ==========================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The tests need well under a thousand cycles, so this only trips on a hang.
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        {sys_rst, radio_mode, preset_mode} = 3'h7;
        {req_up, req_down, detector_a_enable, detector_b_enable} = 4'h0;
        div_int = 8'h01;
        div_frac = 16'h0000;
        trim_step = 16'h0003;
        trim_limit = 16'h000A;
        coef_write = '0;
        mpx_in = '0;
        level_in = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            div_int <= 8'(DIVS[i]);
            div_frac <= 16'(FRACS[i]);
            radio_mode <= (i != 3);
            repeat (10) @(posedge clk);
            count_ticks();
            check(n_tick, 2 * TICKS[i]);
            check(n_dec, (i != 3) ? 3 * TICKS[i] : 0);
        end
        preset_mode <= 1'b0;
        @(posedge clk) req_up <= 1'b1;
        @(posedge clk) req_up <= 1'b0;
        repeat (3) @(negedge clk);
        check(trim_value, -16'sh3);
        @(posedge clk) req_up <= 1'b1;
        repeat (10) @(posedge clk);
        req_up <= 1'b0;
        repeat (3) @(negedge clk);
        check(trim_value, -16'shA);
        @(posedge clk) req_down <= 1'b1;
        repeat (20) @(posedge clk);
        req_down <= 1'b0;
        repeat (3) @(negedge clk);
        check(trim_value, 16'shA);
        @(posedge clk) preset_mode <= 1'b1;
        repeat (2) @(negedge clk);
        check(trim_value, 16'sh0);
        detector_a_enable <= 1'b1;
        wr_coef(COEF_THR_A, 16'h0100);
        wr_coef(COEF_HOLD_A, 16'h0002);
        send_mpx(16'h0000, 16'h0000, 1'b0);
        send_mpx(16'h0200, 16'h0000, 1'b1);
        send_mpx(16'h0210, 16'h0000, 1'b1);
        send_mpx(16'h0220, 16'h0000, 1'b1);
        send_mpx(16'h0230, 16'h0230, 1'b0);
        detector_a_enable <= 1'b0;
        detector_b_enable <= 1'b1;
        send_mpx(16'h1000, 16'h1000, 1'b0);
        wr_coef(COEF_THR_B, 16'h0080);
        wr_coef(COEF_HOLD_B, 16'h0003);
        wr_coef(COEF_DEV_LIMIT, 16'h5000);
        wr_coef(COEF_DEV_HOLD, 16'h0001);
        send_level(9'h010);
        send_level(9'h110);
        send_level(9'h050);
        send_mpx(16'h1010, 16'h1010, 1'b0);
        send_level(9'h0F0);
        send_mpx(16'h1020, 16'h0000, 1'b1);
        // Detector B is still holding its mute, so a pass here shows the override.
        @(posedge clk) mpx_in <= {1'b1, 16'h5800};
        @(negedge clk) check(dynamic_disable, 1);
        @(posedge clk) mpx_in.valid <= 1'b0;
        @(negedge clk) check(mpx_out.data, 16'h5800);
        check(mute_active, 0);
        // The disable covers one more sample, then detector B mutes until its hold ends.
        send_mpx(16'h0100, 16'h0100, 1'b0);
        send_mpx(16'h0100, 16'h0000, 1'b1);
        repeat (3) send_level(9'h0F0);
        send_mpx(16'h0100, 16'h0100, 1'b0);
        give_verdict();
    end
endmodule

bind fm_pilot_clock_and_ignition_blanker blanker_properties #(.FRAC_W(FRAC_W), .DIV_W(DIV_W))
    props (.clk(clk), .sys_rst(sys_rst), .radio_mode(radio_mode), .preset_mode(preset_mode),
    .div_int(div_int), .trim_limit(trim_limit), .loop_up(loop_up), .loop_down(loop_down),
    .sample_clk_en(sample_clk_en), .stereo_dec_en(stereo_dec_en),
    .rds_converter_en(rds_converter_en), .mpx_converter_en(mpx_converter_en),
    .level_filter_en(level_filter_en), .trim_value(trim_value), .mpx_in(mpx_in),
    .mpx_out(mpx_out), .mute_active(mute_active), .dynamic_disable(dynamic_disable));
